// [design/rssx_pkg.sv]
// shared constants for the rotate/set/sleep/subtract execute block
package rssx_pkg;
   // register byte offsets
   localparam logic [4:0] OFS_CTRL   = 5'h00;
   localparam logic [4:0] OFS_WORK   = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_BANK   = 5'h0c;
   localparam logic [4:0] OFS_INDEX  = 5'h10;
   // status and control bit positions
   localparam int BIT_C  = 0;
   localparam int BIT_DC = 1;
   localparam int BIT_Z  = 2;
   localparam int BIT_OV = 3;
   localparam int BIT_N  = 4;
   localparam int BIT_TO = 5;
   localparam int BIT_PD = 6;
   localparam int BIT_SL = 7;
   localparam int BIT_EXT = 0;
   // opcode patterns
   localparam logic [5:0]  OPC_ROTATE = 6'h10;
   localparam logic [6:0]  OPC_SETALL = 7'h34;
   localparam logic [5:0]  OPC_SUBWB  = 6'h15;
   localparam logic [15:0] OPC_HALT   = 16'h0003;
   // addressing
   localparam logic [7:0]  INDEX_LIMIT = 8'h5f;
   localparam logic [7:0]  ACC_SPLIT   = 8'h60;
   localparam logic [3:0]  ACC_HI_BANK = 4'hf;
   localparam logic [3:0]  ACC_LO_BANK = 4'h0;
   localparam logic [7:0]  ALL_ONES    = 8'hff;
   localparam logic [4:0]  FLAGS_RST   = 5'h00;
   typedef enum logic [1:0] {
      RSSX_Q1 = 2'b00,
      RSSX_Q2 = 2'b01,
      RSSX_Q3 = 2'b11,
      RSSX_Q4 = 2'b10
   } rssx_phase_t;
   typedef enum logic [2:0] {
      RSSX_OP_NONE = 3'h0,
      RSSX_OP_ROT  = 3'h1,
      RSSX_OP_SET  = 3'h2,
      RSSX_OP_SUB  = 3'h3,
      RSSX_OP_HALT = 3'h4
   } rssx_op_t;
endpackage : rssx_pkg

// [design/rssx_alu.sv]
// result and flag computation for rotate, set and subtract; halt passes the operand through
`timescale 1ns/1ps
`default_nettype none
module rssx_alu
   import rssx_pkg::*;
(
   input  wire rssx_pkg::rssx_op_t op,
   input  wire logic [7:0]         work,
   input  wire logic [7:0]         opnd,
   input  wire logic [4:0]         flags_in,
   output logic      [7:0]         result,
   output logic      [4:0]         flags_out
);
   logic [8:0] diff;
   logic [4:0] lo;
   always_comb begin
      diff      = {1'b0, work} - {1'b0, opnd} - {8'h00, ~flags_in[BIT_C]};
      lo        = {1'b0, work[3:0]} - {1'b0, opnd[3:0]}
                  - {4'h0, ~flags_in[BIT_C]};
      result    = opnd;
      flags_out = flags_in;
      case (op)
         RSSX_OP_ROT: begin
            result           = {opnd[0], opnd[7:1]};
            flags_out[BIT_N] = result[7];
            flags_out[BIT_Z] = (result == 8'h00);
         end
         RSSX_OP_SET: begin
            result = ALL_ONES;
         end
         RSSX_OP_SUB: begin
            result            = diff[7:0];
            flags_out[BIT_N]  = result[7];
            flags_out[BIT_Z]  = (result == 8'h00);
            flags_out[BIT_C]  = ~diff[8];
            flags_out[BIT_DC] = ~lo[4];
            flags_out[BIT_OV] = (work[7] ^ opnd[7]) & (work[7] ^ result[7]);
         end
         default: begin
            result = opnd;
         end
      endcase
   end
endmodule : rssx_alu
`default_nettype wire

// [design/rssx_exec.sv]
// decode and four-phase execution of rotate, set, halt and subtract
// Summary of operation
// - rotate right moves bit zero into bit seven; only N and Z change
// - destination bit 0 writes work register, 1 writes the file register
// - access bit 0 uses access bank, 1 uses bank select register
// - access 0, extended set on, address up to 5Fh gives indexed mode
// - set instruction writes FFh, flags untouched, bank as usual
// - word 0003h halts the core with oscillator stopped from the edge that ends phase four
// - halt clears the watchdog counter and its postscaler
// - halt sets timeout flag, clears powerdown; watchdog wake clears timeout
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rssx_exec
   import rssx_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // avalon-mm slave
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // instruction from fetch
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_valid,
   output logic             instr_ready,
   // banked data memory
   output logic      [11:0] mem_addr,
   input  wire logic [7:0]  mem_rdata,
   output logic      [7:0]  mem_wdata,
   output logic             mem_we,
   // power management
   input  wire logic        wake_pin,
   input  wire logic        wake_watchdog_pin,
   output logic             osc_stop,
   output logic             watchdog_clear
);
   import rssx_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state
   rssx_phase_t phase_r, phase_nxt;
   rssx_op_t    op_r, op_nxt;
   logic        dest_r, dest_nxt;
   logic [11:0] addr_r, addr_nxt;
   logic [7:0]  opnd_r, opnd_nxt;
   logic [7:0]  res_r, res_nxt;
   logic [4:0]  fres_r, fres_nxt;
   logic [7:0]  work_r, work_nxt;
   logic [4:0]  flags_r, flags_nxt;
   logic        to_r, to_nxt;
   logic        pd_r, pd_nxt;
   logic        asleep_r, asleep_nxt;
   logic        ext_r, ext_nxt;
   logic [3:0]  bank_r, bank_nxt;
   logic [11:0] index_r, index_nxt;
   logic        we_r, we_nxt;
   logic        wclr_r, wclr_nxt;
   logic        ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  wake_s_r, wake_wd_s_r;
   logic [7:0]  alu_res;
   logic [4:0]  alu_flags;
   logic        bus_wr;
   rssx_op_t    dec_op;
   logic [7:0]  dec_f;
   logic        dec_a;

   ////////////////////////////////////////////////////////////////////////
   // wake input synchronisers
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wake_s_r    <= 2'b00;
         wake_wd_s_r <= 2'b00;
      end else begin
         wake_s_r    <= {wake_s_r[0], wake_pin};
         wake_wd_s_r <= {wake_wd_s_r[0], wake_watchdog_pin};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decode
   always_comb begin
      dec_f  = instr_word[7:0];
      dec_a  = instr_word[8];
      dec_op = RSSX_OP_NONE;
      if (instr_word[15:10] == OPC_ROTATE) begin
         dec_op = RSSX_OP_ROT;
      end else if (instr_word[15:9] == OPC_SETALL) begin
         dec_op = RSSX_OP_SET;
      end else if (instr_word[15:10] == OPC_SUBWB) begin
         dec_op = RSSX_OP_SUB;
      end else if (instr_word == OPC_HALT) begin
         dec_op = RSSX_OP_HALT;
      end
   end

   rssx_alu u_alu (
      .op        (op_r),
      .work      (work_r),
      .opnd      (opnd_r),
      .flags_in  (flags_r),
      .result    (alu_res),
      .flags_out (alu_flags)
   );

   // register writes land at the edge that ends the cycle after the wait
   assign bus_wr = avs_write & ack_r;

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      phase_nxt  = phase_r;
      op_nxt     = op_r;
      dest_nxt   = dest_r;
      addr_nxt   = addr_r;
      opnd_nxt   = opnd_r;
      res_nxt    = res_r;
      fres_nxt   = fres_r;
      work_nxt   = work_r;
      flags_nxt  = flags_r;
      to_nxt     = to_r;
      pd_nxt     = pd_r;
      asleep_nxt = asleep_r;
      ext_nxt    = ext_r;
      bank_nxt   = bank_r;
      index_nxt  = index_r;
      we_nxt     = 1'b0;
      wclr_nxt   = 1'b0;
      // software register writes, lower priority than execution
      if (bus_wr) begin
         case (avs_address)
            OFS_CTRL:   ext_nxt   = avs_writedata[BIT_EXT];
            OFS_WORK:   work_nxt  = avs_writedata[7:0];
            OFS_STATUS: flags_nxt = avs_writedata[4:0];
            OFS_BANK:   bank_nxt  = avs_writedata[3:0];
            OFS_INDEX:  index_nxt = avs_writedata[11:0];
            default:    ext_nxt   = ext_r;
         endcase
      end
      case (phase_r)
         RSSX_Q1: begin
            if (instr_valid && !asleep_r) begin
               op_nxt    = dec_op;
               // set instruction always targets the file register
               dest_nxt  = (dec_op == RSSX_OP_SET) ? 1'b1 : instr_word[9];
               phase_nxt = RSSX_Q2;
               if (!dec_a && ext_r && dec_f <= INDEX_LIMIT) begin
                  addr_nxt = 12'(index_r + {4'h0, dec_f});
               end else if (!dec_a) begin
                  addr_nxt = {(dec_f < ACC_SPLIT) ? ACC_LO_BANK
                                                  : ACC_HI_BANK, dec_f};
               end else begin
                  addr_nxt = {bank_r, dec_f};
               end
            end
         end
         RSSX_Q2: begin
            opnd_nxt  = mem_rdata;
            phase_nxt = RSSX_Q3;
         end
         RSSX_Q3: begin
            res_nxt   = alu_res;
            fres_nxt  = alu_flags;
            phase_nxt = RSSX_Q4;
         end
         RSSX_Q4: begin
            phase_nxt = RSSX_Q1;
            if (op_r == RSSX_OP_HALT) begin
               asleep_nxt = 1'b1;
               wclr_nxt   = 1'b1;
               to_nxt     = 1'b1;
               pd_nxt     = 1'b0;
            end else if (op_r != RSSX_OP_NONE) begin
               flags_nxt = fres_r;
               if (dest_r) begin
                  we_nxt = 1'b1;
               end else begin
                  work_nxt = res_r;
               end
            end
         end
         default: phase_nxt = RSSX_Q1;
      endcase
      if (asleep_r && (wake_s_r[1] || wake_wd_s_r[1])) begin
         asleep_nxt = 1'b0;
         if (wake_wd_s_r[1]) begin
            to_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phase_r  <= RSSX_Q1;
         op_r     <= RSSX_OP_NONE;
         dest_r   <= 1'b0;
         addr_r   <= 12'h000;
         opnd_r   <= 8'h00;
         res_r    <= 8'h00;
         fres_r   <= FLAGS_RST;
         work_r   <= 8'h00;
         flags_r  <= FLAGS_RST;
         to_r     <= 1'b1;
         pd_r     <= 1'b1;
         asleep_r <= 1'b0;
         ext_r    <= 1'b0;
         bank_r   <= 4'h0;
         index_r  <= 12'h000;
         we_r     <= 1'b0;
         wclr_r   <= 1'b0;
      end else begin
         phase_r  <= phase_nxt;
         op_r     <= op_nxt;
         dest_r   <= dest_nxt;
         addr_r   <= addr_nxt;
         opnd_r   <= opnd_nxt;
         res_r    <= res_nxt;
         fres_r   <= fres_nxt;
         work_r   <= work_nxt;
         flags_r  <= flags_nxt;
         to_r     <= to_nxt;
         pd_r     <= pd_nxt;
         asleep_r <= asleep_nxt;
         ext_r    <= ext_nxt;
         bank_r   <= bank_nxt;
         index_r  <= index_nxt;
         we_r     <= we_nxt;
         wclr_r   <= wclr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait cycle, then answer
   always_comb begin
      ack_nxt   = (avs_read | avs_write) & ~ack_r;
      rdata_nxt = 32'h0000_0000;
      if (avs_read) begin
         case (avs_address)
            OFS_CTRL:   rdata_nxt = {31'h0, ext_r};
            OFS_WORK:   rdata_nxt = {24'h0, work_r};
            OFS_STATUS: rdata_nxt = {24'h0, asleep_r, pd_r, to_r, flags_r};
            OFS_BANK:   rdata_nxt = {28'h0, bank_r};
            OFS_INDEX:  rdata_nxt = {20'h0, index_r};
            default:    rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else begin
         ack_r   <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign avs_readdata    = rdata_r;
   assign instr_ready     = (phase_r == RSSX_Q1) & ~asleep_r;
   assign mem_addr        = addr_r;
   assign mem_wdata       = res_r;
   assign mem_we          = we_r;
   assign osc_stop        = asleep_r;
   assign watchdog_clear  = wclr_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_take;
      phase_r == RSSX_Q1 && instr_valid && !asleep_r;
   endsequence
   sequence s_rest;
      phase_r == RSSX_Q2 ##1 phase_r == RSSX_Q3 ##1 phase_r == RSSX_Q4
      ##1 phase_r == RSSX_Q1;
   endsequence

   property p_cycle;
      @(posedge clk_sys) disable iff (!rstn) s_take |=> s_rest;
   endproperty
   a_cycle: assert property (p_cycle)
      else $error("instruction did not take four phases");

   property p_rotate;
      @(posedge clk_sys) disable iff (!rstn)
      (phase_r == RSSX_Q3 && op_r == RSSX_OP_ROT)
      |=> res_r == {$past(opnd_r[0]), $past(opnd_r[7:1])};
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate result wrong");

   property p_rot_flags;
      @(posedge clk_sys) disable iff (!rstn)
      (phase_r == RSSX_Q4 && op_r == RSSX_OP_ROT && !bus_wr)
      |=> flags_r[BIT_C] == $past(flags_r[BIT_C])
          && flags_r[BIT_OV] == $past(flags_r[BIT_OV])
          && flags_r[BIT_DC] == $past(flags_r[BIT_DC])
          && flags_r[BIT_N] == res_r[7]
          && flags_r[BIT_Z] == (res_r == 8'h00);
   endproperty
   a_rot_flags: assert property (p_rot_flags)
      else $error("rotate touched wrong flags");

   property p_dest;
      @(posedge clk_sys) disable iff (!rstn)
      (phase_r == RSSX_Q4 && op_r != RSSX_OP_NONE && op_r != RSSX_OP_HALT)
      |=> (mem_we == $past(dest_r))
          && (!$past(dest_r) -> work_r == mem_wdata);
   endproperty
   a_dest: assert property (p_dest)
      else $error("destination select wrong");

   property p_bank;
      @(posedge clk_sys) disable iff (!rstn)
      (s_take and instr_word[8]) |=> mem_addr == {$past(bank_r),
                                                 $past(instr_word[7:0])};
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank select address wrong");

   property p_index;
      @(posedge clk_sys) disable iff (!rstn)
      (s_take and !instr_word[8] && ext_r && instr_word[7:0] <= INDEX_LIMIT)
      |=> mem_addr == $past(index_r) + {4'h0, $past(instr_word[7:0])};
   endproperty
   a_index: assert property (p_index)
      else $error("indexed address wrong");

   property p_set;
      @(posedge clk_sys) disable iff (!rstn)
      (phase_r == RSSX_Q4 && op_r == RSSX_OP_SET && !bus_wr)
      |=> mem_we && mem_wdata == ALL_ONES && $stable(flags_r);
   endproperty
   a_set: assert property (p_set)
      else $error("set instruction wrong");

   property p_halt;
      @(posedge clk_sys) disable iff (!rstn)
      (phase_r == RSSX_Q4 && op_r == RSSX_OP_HALT)
      |=> osc_stop && watchdog_clear && to_r && !pd_r && !mem_we;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt did not sleep and clear watchdog");

   property p_wd_wake;
      @(posedge clk_sys) disable iff (!rstn)
      (asleep_r && wake_wd_s_r[1]) |=> !osc_stop && !to_r;
   endproperty
   a_wd_wake: assert property (p_wd_wake)
      else $error("watchdog wake did not clear timeout");

   property p_sub;
      @(posedge clk_sys) disable iff (!rstn)
      (phase_r == RSSX_Q3 && op_r == RSSX_OP_SUB)
      |=> res_r == $past(work_r) - $past(opnd_r)
                   - {7'h00, ~$past(flags_r[BIT_C])};
   endproperty
   a_sub: assert property (p_sub)
      else $error("subtract with borrow result wrong");
endmodule : rssx_exec
`default_nettype wire

// [sim/rssx_mem_model.sv]
// banked data memory model on the far side of the execute block
`timescale 1ns/1ps
`default_nettype none
module rssx_mem_model (
   input  wire logic        clk_sys,
   input  wire logic [11:0] mem_addr,
   output logic      [7:0]  mem_rdata,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_we
);
   logic [7:0]  mem [4096];
   logic [11:0] last_wa;
   initial begin
      last_wa = 12'h000;
      foreach (mem[i]) mem[i] = 8'h00;
   end
   // combinational read, valid in the same cycle as the address
   assign mem_rdata = mem[mem_addr];
   always @(posedge clk_sys) begin
      if (mem_we === 1'b1) begin
         mem[mem_addr] <= mem_wdata;
         last_wa       <= mem_addr;
      end
   end
endmodule : rssx_mem_model
`default_nettype wire

// [sim/rotate_set_sleep_subtract_exec_tb.sv]
// self-checking bench for the rotate/set/halt/subtract execute block
`timescale 1ns/1ps
`default_nettype none
module rotate_set_sleep_subtract_exec_tb;
   import rssx_pkg::*;
   typedef struct packed {
      logic [15:0] op;
      logic [7:0]  w_in;
      logic [7:0]  f_in;
      logic [4:0]  st_in;
      logic [7:0]  exp_w;
      logic [7:0]  exp_f;
      logic [4:0]  exp_st;
      logic        exp_we;
   } rssx_row_t;
   typedef struct packed {
      logic        ext;
      logic [15:0] op;
      logic [11:0] exp_a;
   } rssx_bank_t;
   logic        clk_sys;
   logic        rstn;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [15:0] instr_word;
   logic        instr_valid;
   logic        instr_ready;
   logic [11:0] mem_addr;
   logic [7:0]  mem_rdata;
   logic [7:0]  mem_wdata;
   logic        mem_we;
   logic        wake_pin;
   logic        wake_watchdog_pin;
   logic        osc_stop;
   logic        watchdog_clear;
   int          fails;
   int          checked;
   int          cyc;
   int          wdc;
   rssx_row_t   rows [9];
   rssx_bank_t  banks [7];

   rssx_exec dut (
      .clk_sys           (clk_sys),
      .rstn              (rstn),
      .avs_address       (avs_address),
      .avs_read          (avs_read),
      .avs_write         (avs_write),
      .avs_writedata     (avs_writedata),
      .avs_readdata      (avs_readdata),
      .avs_waitrequest   (avs_waitrequest),
      .instr_word        (instr_word),
      .instr_valid       (instr_valid),
      .instr_ready       (instr_ready),
      .mem_addr          (mem_addr),
      .mem_rdata         (mem_rdata),
      .mem_wdata         (mem_wdata),
      .mem_we            (mem_we),
      .wake_pin          (wake_pin),
      .wake_watchdog_pin (wake_watchdog_pin),
      .osc_stop          (osc_stop),
      .watchdog_clear    (watchdog_clear)
   );
   rssx_mem_model mem (
      .clk_sys   (clk_sys),
      .mem_addr  (mem_addr),
      .mem_rdata (mem_rdata),
      .mem_wdata (mem_wdata),
      .mem_we    (mem_we)
   );

   ////////////////////////////////////////////////////////////////////////
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (watchdog_clear === 1'b1) wdc <= wdc + 1;
      if (cyc == 6000) begin
         fails++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d failures %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd

   // issue one word; we is the write strobe seen in the cycle after q4
   task automatic exec(input logic [15:0] op, output logic we);
      instr_word  <= op;
      instr_valid <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (instr_ready !== 1'b1);
      instr_valid <= 1'b0;
      repeat (4) @(posedge clk_sys);
      we = mem_we;
   endtask : exec

   task automatic reset_check;
      logic [31:0] q;
      rstn <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      rd(OFS_STATUS, q);
      chk(q, 32'h60);
      rd(OFS_WORK, q);
      chk(q, 32'h0);
   endtask : reset_check

   task automatic halt_wake(input logic by_wd, input logic [2:0] exp_hi);
      logic        we;
      logic [31:0] q;
      int          n;
      n = wdc;
      exec(OPC_HALT, we);
      chk(osc_stop, 1'b1);
      rd(OFS_STATUS, q);
      chk(q[7:5], 3'b101);
      chk(wdc - n, 32'h1);
      chk(instr_ready, 1'b0);
      wake_watchdog_pin <= by_wd;
      wake_pin          <= !by_wd;
      n = 0;
      while (osc_stop !== 1'b0 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      wake_watchdog_pin <= 1'b0;
      wake_pin          <= 1'b0;
      rd(OFS_STATUS, q);
      chk(q[7:5], exp_hi);
   endtask : halt_wake

   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] q;
      logic        we;
      clk_sys = 1'b0;
      rstn = 1'b0;
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      {instr_word, instr_valid, wake_pin, wake_watchdog_pin} = '0;
      {fails, checked, cyc, wdc} = '0;
      rows = '{
         '{16'h4220, 8'h00, 8'hd7, 5'h0b, 8'h00, 8'heb, 5'h1b, 1'b1},
         '{16'h4020, 8'h55, 8'hd7, 5'h00, 8'heb, 8'hd7, 5'h10, 1'b0},
         '{16'h4220, 8'h00, 8'h00, 5'h10, 8'h00, 8'h00, 5'h04, 1'b1},
         '{16'h6820, 8'h33, 8'h5a, 5'h15, 8'h33, 8'hff, 5'h15, 1'b1},
         '{16'h5620, 8'h02, 8'h03, 5'h01, 8'h02, 8'hff, 5'h10, 1'b1},
         '{16'h5420, 8'h05, 8'h02, 5'h01, 8'h03, 8'h02, 5'h03, 1'b0},
         '{16'h5620, 8'h02, 8'h01, 5'h00, 8'h02, 8'h00, 5'h07, 1'b1},
         '{16'h5420, 8'h80, 8'h01, 5'h01, 8'h7f, 8'h01, 5'h09, 1'b0},
         '{16'hffff, 8'h44, 8'h12, 5'h05, 8'h44, 8'h12, 5'h05, 1'b0}};
      banks = '{
         '{1'b0, 16'h6920, 12'h520}, '{1'b0, 16'h685f, 12'h05f},
         '{1'b0, 16'h6860, 12'hf60}, '{1'b1, 16'h685f, 12'h35f},
         '{1'b1, 16'h6860, 12'hf60}, '{1'b1, 16'h6810, 12'h310},
         '{1'b1, 16'h6910, 12'h510}};
      reset_check();
      foreach (rows[i]) begin
         mem.mem[12'h020] = rows[i].f_in;
         wr(OFS_WORK, {24'h0, rows[i].w_in});
         wr(OFS_STATUS, {27'h0, rows[i].st_in});
         exec(rows[i].op, we);
         chk(we, rows[i].exp_we);
         rd(OFS_WORK, q);
         chk(q, {24'h0, rows[i].exp_w});
         rd(OFS_STATUS, q);
         chk(q[4:0], rows[i].exp_st);
         chk(mem.mem[12'h020], rows[i].exp_f);
      end
      // bank, access and indexed address selection
      wr(OFS_BANK, 32'h5);
      wr(OFS_INDEX, 32'h300);
      foreach (banks[i]) begin
         wr(OFS_CTRL, {31'h0, banks[i].ext});
         mem.mem[banks[i].exp_a] = 8'h00;
         exec(banks[i].op, we);
         @(negedge clk_sys);
         chk(mem.last_wa, banks[i].exp_a);
         chk(mem.mem[banks[i].exp_a], 8'hff);
         @(posedge clk_sys);
      end
      wr(OFS_CTRL, 32'h0);
      // consecutive rotates on one byte
      mem.mem[12'h020] = 8'h01;
      exec(16'h4220, we);
      exec(16'h4220, we);
      rd(OFS_WORK, q);
      chk(mem.mem[12'h020], 8'h40);
      // unmapped place
      wr(5'h14, 32'hff);
      rd(5'h14, q);
      chk(q, 32'h0);
      halt_wake(1'b1, 3'b000);
      halt_wake(1'b0, 3'b001);
      reset_check();
      close_out();
   end
endmodule : rotate_set_sleep_subtract_exec_tb
`default_nettype wire
